// *** logic/bus_status_pkg.sv ***
package bus_status_pkg;
	// ==========================================================
	// Register bus
	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;
	localparam logic [3:0] OFS_STATUS = 4'h0;
	localparam logic [3:0] OFS_TXBUF = 4'h4;
	localparam logic [3:0] OFS_RXBUF = 4'h8;
	localparam logic [15:0] STATUS_RESET = 16'h0000;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	// ==========================================================
	// Status field positions
	localparam int B_ACK = 15;
	localparam int B_TRS = 14;
	localparam int B_BUSCOLL = 10;
	localparam int B_GC = 9;
	localparam int B_A10 = 8;
	localparam int B_WCOL = 7;
	localparam int B_OV = 6;
	localparam int B_DA = 5;
	localparam int B_P = 4;
	localparam int B_S = 3;
	localparam int B_RXFULL = 1;
	localparam int B_TXFULL = 0;
	// ==========================================================
	// Bus events, first field is the top bit
	localparam int EV_N = 11;
	localparam int EV_START = 10;
	localparam int EV_STOP = 9;
	localparam int EV_COLL = 8;
	localparam int EV_ADDR = 7;
	localparam int EV_GCALL = 6;
	localparam int EV_TEN = 5;
	localparam int EV_DATA = 4;
	localparam int EV_RXBYTE = 3;
	localparam int EV_ACK = 2;
	localparam int EV_TXBEG = 1;
	localparam int EV_TXEND = 0;
	typedef struct packed {
		logic start_seen;
		logic stop_seen;
		logic collision;
		logic addr_match;
		logic gen_call;
		logic ten_bit_match;
		logic slave_data_rx;
		logic rx_byte_done;
		logic ack_phase_end;
		logic tx_begin;
		logic tx_end;
	} link_events_t;
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;
endpackage

// *** logic/serial_status_flags.sv ***
// Added by the designer: the register addresses and the strobed register port.
`timescale 1ns/1ps
// What this block does
// RQ1 - Collision during master operation sets collision flag
// RQ2 - Second ten-bit address byte match sets flag
// RQ3 - Stop condition clears ten-bit match flag
// RQ4 - Busy transmit write discarded, sets write collision
// RQ5 - Byte arriving on full buffer sets overflow
// RQ6 - Address match clears data/address flag
// RQ7 - Slave data byte sets data/address flag
// RQ8 - Stop sets stop flag; start clears it
// RQ9 - Start sets start flag; stop clears it
// RQ10 - Received byte sets full; software read clears
// RQ11 - Transmit write sets full; completion clears
// RQ12 - Acknowledge phase records slave acknowledge bit
// RQ13 - Transmit-active flag spans eight bits plus acknowledge
module serial_status_flags (
	// Clocks and reset
	input wire logic ref_clk,
	input wire logic link_clk,
	input wire logic resetn,
	// Register port
	input wire bus_status_pkg::reg_req_t req,
	output logic [bus_status_pkg::DATA_W-1:0] rdata,
	// Link side, on link_clk
	input wire bus_status_pkg::link_events_t link_ev,
	input wire logic master_op,
	input wire logic engine_busy,
	input wire logic ack_bit,
	input wire logic [7:0] rx_byte,
	// Transmit data toward the engine
	output logic [7:0] tx_data,
	output logic tx_full
);
	// ==========================================================
	// Link domain capture
	logic [bus_status_pkg::EV_N-1:0] ev_vec;
	logic [bus_status_pkg::EV_N-1:0] ev_gated;
	logic [bus_status_pkg::EV_N-1:0] tog_reg;
	logic ack_hold_reg;
	logic [7:0] rx_hold_reg;
	logic busy_link_reg;

	assign ev_vec = link_ev;
	always_comb begin
		ev_gated = ev_vec;
		// Collisions outside a master operation are not ours to flag
		ev_gated[bus_status_pkg::EV_COLL] = ev_vec[bus_status_pkg::EV_COLL] & master_op; // see RQ1
	end

	always_ff @(posedge link_clk or negedge resetn) begin
		if (!resetn) begin
			tog_reg <= '0;
		end else begin
			tog_reg <= tog_reg ^ ev_gated;
		end
	end

	// Held words are read by ref_clk only after their toggle has crossed
	always_ff @(posedge link_clk or negedge resetn) begin
		if (!resetn) begin
			ack_hold_reg <= 1'b0;
			rx_hold_reg <= bus_status_pkg::BYTE_RESET;
		end else begin
			if (ev_vec[bus_status_pkg::EV_ACK]) begin
				ack_hold_reg <= ack_bit;
			end
			if (ev_vec[bus_status_pkg::EV_RXBYTE]) begin
				rx_hold_reg <= rx_byte;
			end
		end
	end

	always_ff @(posedge link_clk or negedge resetn) begin
		if (!resetn) begin
			busy_link_reg <= 1'b0;
		end else begin
			busy_link_reg <= engine_busy;
		end
	end

	// ==========================================================
	// Crossing into ref_clk
	logic [bus_status_pkg::EV_N-1:0] s1_reg;
	logic [bus_status_pkg::EV_N-1:0] s2_reg;
	logic [bus_status_pkg::EV_N-1:0] s3_reg;
	logic [bus_status_pkg::EV_N-1:0] ev_p;
	logic busy_s1_reg;
	logic busy_s2_reg;

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
			busy_s1_reg <= 1'b0;
			busy_s2_reg <= 1'b0;
		end else begin
			s1_reg <= tog_reg;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			busy_s1_reg <= busy_link_reg;
			busy_s2_reg <= busy_s1_reg;
		end
	end
	assign ev_p = s2_reg ^ s3_reg;

	logic p_start;
	logic p_stop;
	logic p_coll;
	logic p_addr;
	logic p_gcall;
	logic p_ten;
	logic p_data;
	logic p_rx;
	logic p_ack;
	logic p_txbeg;
	logic p_txend;
	assign p_start = ev_p[bus_status_pkg::EV_START];
	assign p_stop = ev_p[bus_status_pkg::EV_STOP];
	assign p_coll = ev_p[bus_status_pkg::EV_COLL];
	assign p_addr = ev_p[bus_status_pkg::EV_ADDR];
	assign p_gcall = ev_p[bus_status_pkg::EV_GCALL];
	assign p_ten = ev_p[bus_status_pkg::EV_TEN];
	assign p_data = ev_p[bus_status_pkg::EV_DATA];
	assign p_rx = ev_p[bus_status_pkg::EV_RXBYTE];
	assign p_ack = ev_p[bus_status_pkg::EV_ACK];
	assign p_txbeg = ev_p[bus_status_pkg::EV_TXBEG];
	assign p_txend = ev_p[bus_status_pkg::EV_TXEND];

	// ==========================================================
	// Register decode
	logic wr_status;
	logic wr_tx;
	logic rd_rx;
	logic busy;
	assign wr_status = req.wr && (req.addr == bus_status_pkg::OFS_STATUS);
	assign wr_tx = req.wr && (req.addr == bus_status_pkg::OFS_TXBUF);
	assign rd_rx = req.rd && (req.addr == bus_status_pkg::OFS_RXBUF);

	logic slave_ack_result_reg;
	logic master_tx_active_reg;
	logic bus_collision_flag_reg;
	logic general_call_seen_reg;
	logic ten_bit_match_flag_reg;
	logic write_collision_flag_reg;
	logic rx_overflow_flag_reg;
	logic data_flag_reg;
	logic stop_flag_reg;
	logic start_flag_reg;
	logic rx_buffer_full_reg;
	logic tx_buffer_full_reg;
	logic [7:0] transmit_buffer_reg;
	logic [7:0] receive_buffer_reg;
	logic [bus_status_pkg::DATA_W-1:0] rdata_reg;
	logic [bus_status_pkg::DATA_W-1:0] status_next;

	assign busy = tx_buffer_full_reg | master_tx_active_reg | busy_s2_reg;

	// Writing a zero clears a clearable bit; a same-cycle event wins
	logic clr_coll;
	logic clr_wcol;
	logic clr_ov;
	logic clr_p;
	logic clr_s;
	assign clr_coll = wr_status && !req.wdata[bus_status_pkg::B_BUSCOLL];
	assign clr_wcol = wr_status && !req.wdata[bus_status_pkg::B_WCOL];
	assign clr_ov = wr_status && !req.wdata[bus_status_pkg::B_OV];
	assign clr_p = wr_status && !req.wdata[bus_status_pkg::B_P];
	assign clr_s = wr_status && !req.wdata[bus_status_pkg::B_S];

	// ==========================================================
	// Master flags
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			bus_collision_flag_reg <= 1'b0;
		end else if (p_coll) begin
			bus_collision_flag_reg <= 1'b1; // see RQ1
		end else if (clr_coll) begin
			bus_collision_flag_reg <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			slave_ack_result_reg <= 1'b0;
		end else if (p_ack) begin
			slave_ack_result_reg <= ack_hold_reg; // see RQ12
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			master_tx_active_reg <= 1'b0;
		end else if (p_txbeg) begin
			master_tx_active_reg <= 1'b1; // see RQ13
		end else if (p_txend) begin
			master_tx_active_reg <= 1'b0; // see RQ13
		end
	end

	// ==========================================================
	// Address flags, both end at stop
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			ten_bit_match_flag_reg <= 1'b0;
			general_call_seen_reg <= 1'b0;
		end else begin
			if (p_ten) begin
				ten_bit_match_flag_reg <= 1'b1; // see RQ2
			end else if (p_stop) begin
				ten_bit_match_flag_reg <= 1'b0; // see RQ3
			end
			if (p_gcall) begin
				general_call_seen_reg <= 1'b1;
			end else if (p_stop) begin
				general_call_seen_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			data_flag_reg <= 1'b0;
		end else if (p_data) begin
			data_flag_reg <= 1'b1; // see RQ7
		end else if (p_addr) begin
			data_flag_reg <= 1'b0; // see RQ6
		end
	end

	// Start wins when both conditions land together
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			start_flag_reg <= 1'b0;
			stop_flag_reg <= 1'b0;
		end else begin
			if (p_start) begin
				start_flag_reg <= 1'b1; // see RQ9
			end else if (p_stop || clr_s) begin
				start_flag_reg <= 1'b0; // see RQ9
			end
			if (p_start) begin
				stop_flag_reg <= 1'b0; // see RQ8
			end else if (p_stop) begin
				stop_flag_reg <= 1'b1; // see RQ8
			end else if (clr_p) begin
				stop_flag_reg <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Transmit buffer
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			transmit_buffer_reg <= bus_status_pkg::BYTE_RESET;
			tx_buffer_full_reg <= 1'b0;
		end else begin
			if (wr_tx && !busy) begin
				transmit_buffer_reg <= req.wdata[7:0];
				tx_buffer_full_reg <= 1'b1; // see RQ11
			end else if (p_txend) begin
				tx_buffer_full_reg <= 1'b0; // see RQ11
			end
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			write_collision_flag_reg <= 1'b0;
		end else if (wr_tx && busy) begin
			write_collision_flag_reg <= 1'b1; // see RQ4
		end else if (clr_wcol) begin
			write_collision_flag_reg <= 1'b0;
		end
	end

	// ==========================================================
	// Receive buffer; an overflowing byte is dropped, the old one kept
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			receive_buffer_reg <= bus_status_pkg::BYTE_RESET;
			rx_buffer_full_reg <= 1'b0;
		end else begin
			if (p_rx && !rx_buffer_full_reg) begin
				receive_buffer_reg <= rx_hold_reg;
				rx_buffer_full_reg <= 1'b1; // see RQ10
			end else if (rd_rx) begin
				rx_buffer_full_reg <= 1'b0; // see RQ10
			end
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			rx_overflow_flag_reg <= 1'b0;
		end else if (p_rx && rx_buffer_full_reg) begin
			rx_overflow_flag_reg <= 1'b1; // see RQ5
		end else if (clr_ov) begin
			rx_overflow_flag_reg <= 1'b0;
		end
	end

	// ==========================================================
	// Read path
	always_comb begin
		status_next = bus_status_pkg::STATUS_RESET;
		status_next[bus_status_pkg::B_ACK] = slave_ack_result_reg;
		status_next[bus_status_pkg::B_TRS] = master_tx_active_reg;
		status_next[bus_status_pkg::B_BUSCOLL] = bus_collision_flag_reg;
		status_next[bus_status_pkg::B_GC] = general_call_seen_reg;
		status_next[bus_status_pkg::B_A10] = ten_bit_match_flag_reg;
		status_next[bus_status_pkg::B_WCOL] = write_collision_flag_reg;
		status_next[bus_status_pkg::B_OV] = rx_overflow_flag_reg;
		status_next[bus_status_pkg::B_DA] = data_flag_reg;
		status_next[bus_status_pkg::B_P] = stop_flag_reg;
		status_next[bus_status_pkg::B_S] = start_flag_reg;
		status_next[bus_status_pkg::B_RXFULL] = rx_buffer_full_reg;
		status_next[bus_status_pkg::B_TXFULL] = tx_buffer_full_reg;
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			rdata_reg <= '0;
		end else if (!req.rd) begin
			rdata_reg <= '0;
		end else begin
			case (req.addr)
				bus_status_pkg::OFS_STATUS: begin
					rdata_reg <= status_next;
				end
				bus_status_pkg::OFS_TXBUF: begin
					rdata_reg <= {8'h00, transmit_buffer_reg};
				end
				bus_status_pkg::OFS_RXBUF: begin
					rdata_reg <= {8'h00, receive_buffer_reg};
				end
				default: begin
					rdata_reg <= '0;
				end
			endcase
		end
	end

	assign rdata = rdata_reg;
	assign tx_data = transmit_buffer_reg;
	assign tx_full = tx_buffer_full_reg;

	// ==========================================================
	// Checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	a_coll_set: assert property (p_coll |=> bus_collision_flag_reg) // see RQ1
		else $error("collision not flagged");
	a_ten_set: assert property (p_ten |=> ten_bit_match_flag_reg) // see RQ2
		else $error("ten-bit match not flagged");
	a_ten_stop: assert property (p_stop && !p_ten |=> !ten_bit_match_flag_reg) // see RQ3
		else $error("ten-bit flag survived stop");
	a_wcol_drop: assert property (wr_tx && busy |=> write_collision_flag_reg // see RQ4
		&& $stable(transmit_buffer_reg))
		else $error("busy write not discarded");
	a_ov_keep: assert property (p_rx && rx_buffer_full_reg |=> rx_overflow_flag_reg // see RQ5
		&& $stable(receive_buffer_reg))
		else $error("overflow mishandled");
	a_da_addr: assert property (p_addr && !p_data |=> !data_flag_reg) // see RQ6
		else $error("address did not clear data flag");
	a_da_data: assert property (p_data |=> data_flag_reg) // see RQ7
		else $error("data byte did not set flag");
	a_stop_last: assert property (p_stop && !p_start |=> stop_flag_reg // see RQ8
		&& !start_flag_reg)
		else $error("stop flags wrong");
	a_start_last: assert property (p_start |=> start_flag_reg && !stop_flag_reg) // see RQ9
		else $error("start flags wrong");
	a_rxf_read: assert property (rd_rx && !p_rx |=> !rx_buffer_full_reg) // see RQ10
		else $error("read did not empty buffer");
	a_txf_write: assert property (wr_tx && !busy |=> tx_buffer_full_reg // see RQ11
		&& tx_data == $past(req.wdata[7:0]))
		else $error("transmit write not taken");
	a_ack_take: assert property (p_ack |=> slave_ack_result_reg == $past(ack_hold_reg)) // see RQ12
		else $error("ack result not recorded");
	a_trs_span: assert property (p_txbeg |=> master_tx_active_reg) // see RQ13
		else $error("transmit-active not raised");
endmodule

// *** verification/link_partner.sv ***
`timescale 1ns/1ps
// ==========================================================
// Far side of the link: bus engine events on a gated clock
module link_partner (
	// Link clock, runs only during a burst
	output logic link_clk,
	// Events and levels
	output bus_status_pkg::link_events_t link_ev,
	output logic master_op,
	output logic engine_busy,
	output logic ack_bit,
	output logic [7:0] rx_byte
);
	initial begin
		link_clk = 1'b0;
		link_ev = '0;
		master_op = 1'b0;
		engine_busy = 1'b0;
		ack_bit = 1'b0;
		rx_byte = 8'h00;
	end

	// Levels change only while the clock stands still, so no edge can catch them mid-change
	task automatic set_levels(input logic mop, input logic busy, input logic ack,
		input logic [7:0] b);
		master_op = mop;
		engine_busy = busy;
		ack_bit = ack;
		rx_byte = b;
	endtask

	// One-cycle event pulse, then two idle cycles; clock stops afterwards
	task automatic fire(input bus_status_pkg::link_events_t ev);
		#5.3;
		link_ev = ev;
		repeat (3) begin
			#16 link_clk = 1'b1;
			#32 link_clk = 1'b0;
			link_ev = '0;
			#16;
		end
	endtask
endmodule

// *** verification/serial_status_flags_bench.sv ***
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin err_count++; \
	$display("Error %s expected %h seen %h", nm, e, g); end end
// ==========================================================
// Bench for the status flag block
module serial_status_flags_bench;
	logic ref_clk;
	logic resetn;
	bus_status_pkg::reg_req_t req;
	logic [15:0] rdata;
	logic link_clk;
	bus_status_pkg::link_events_t link_ev;
	logic master_op;
	logic engine_busy;
	logic ack_bit;
	logic [7:0] rx_byte;
	logic [7:0] tx_data;
	logic tx_full;
	int err_count;
	int total_checks;
	logic [15:0] st;
	logic [15:0] d;

	link_partner far (
		.link_clk(link_clk),
		.link_ev(link_ev),
		.master_op(master_op),
		.engine_busy(engine_busy),
		.ack_bit(ack_bit),
		.rx_byte(rx_byte)
	);

	serial_status_flags dut (
		.ref_clk(ref_clk),
		.link_clk(link_clk),
		.resetn(resetn),
		.req(req),
		.rdata(rdata),
		.link_ev(link_ev),
		.master_op(master_op),
		.engine_busy(engine_busy),
		.ack_bit(ack_bit),
		.rx_byte(rx_byte),
		.tx_data(tx_data),
		.tx_full(tx_full)
	);

	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	// ==========================================================
	// Register port tasks
	task automatic wr(input logic [3:0] a, input logic [15:0] v);
		@(posedge ref_clk);
		req.addr <= a;
		req.wdata <= v;
		req.wr <= 1'b1;
		@(posedge ref_clk);
		req.wr <= 1'b0;
		#1;
	endtask

	// Data stand only in the cycle after the strobe, so sample just past that edge
	task automatic rd(input logic [3:0] a, output logic [15:0] v);
		@(posedge ref_clk);
		req.addr <= a;
		req.rd <= 1'b1;
		@(posedge ref_clk);
		req.rd <= 1'b0;
		#1;
		v = rdata;
	endtask

	task automatic chk_st(input string nm);
		logic [15:0] v;
		rd(bus_status_pkg::OFS_STATUS, v);
		`CHK(nm, st, v)
	endtask

	// Write-0-clears: every other bit written as 1 is left alone
	task automatic clr(input int b);
		wr(bus_status_pkg::OFS_STATUS, ~(16'h0001 << b));
		st[b] = 1'b0;
	endtask

	task automatic ev(input int idx);
		far.fire(bus_status_pkg::link_events_t'(11'h001 << idx));
	endtask

	task automatic wrap_up;
		if (err_count == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	initial begin
		#200000;
		err_count++;
		wrap_up;
	end

	// ==========================================================
	// Main sequence
	initial begin
		err_count = 0;
		total_checks = 0;
		req = '0;
		resetn = 1'b0;
		st = bus_status_pkg::STATUS_RESET;
		// Link flops reset asynchronously; a three-cycle idle burst still runs while reset is low
		far.fire('0);
		repeat (12) @(posedge ref_clk);
		resetn <= 1'b1;
		chk_st("reset");
		rd(4'hC, d);
		`CHK("unmapped", 16'h0000, d)
		wr(bus_status_pkg::OFS_TXBUF, 16'h0055);
		st[bus_status_pkg::B_TXFULL] = 1'b1;
		`CHK("tx_full", 1'b1, tx_full)
		`CHK("tx_data", 8'h55, tx_data)
		rd(bus_status_pkg::OFS_TXBUF, d);
		`CHK("tx buffer", 16'h0055, d)
		wr(bus_status_pkg::OFS_TXBUF, 16'h00AA);
		st[bus_status_pkg::B_WCOL] = 1'b1;
		`CHK("tx_data kept", 8'h55, tx_data)
		chk_st("wcol full");
		clr(bus_status_pkg::B_WCOL);
		chk_st("wcol clear");
		ev(bus_status_pkg::EV_TXEND);
		st[bus_status_pkg::B_TXFULL] = 1'b0;
		chk_st("tx end");
		far.set_levels(1'b0, 1'b1, 1'b0, 8'h00);
		// The busy level is registered on link edges, so the gated clock must run
		far.fire('0);
		wr(bus_status_pkg::OFS_TXBUF, 16'h0011);
		st[bus_status_pkg::B_WCOL] = 1'b1;
		`CHK("tx_full busy", 1'b0, tx_full)
		chk_st("wcol busy");
		far.set_levels(1'b0, 1'b0, 1'b1, 8'h00);
		far.fire('0);
		clr(bus_status_pkg::B_WCOL);
		ev(bus_status_pkg::EV_TXBEG);
		st[bus_status_pkg::B_TRS] = 1'b1;
		chk_st("tx active");
		ev(bus_status_pkg::EV_ACK);
		st[bus_status_pkg::B_ACK] = 1'b1;
		chk_st("nack");
		ev(bus_status_pkg::EV_TXEND);
		st[bus_status_pkg::B_TRS] = 1'b0;
		chk_st("tx done");
		ev(bus_status_pkg::EV_TXBEG);
		far.set_levels(1'b0, 1'b0, 1'b0, 8'h00);
		ev(bus_status_pkg::EV_ACK);
		ev(bus_status_pkg::EV_TXEND);
		st[bus_status_pkg::B_ACK] = 1'b0;
		chk_st("ack");
		ev(bus_status_pkg::EV_COLL);
		chk_st("coll idle");
		far.set_levels(1'b1, 1'b0, 1'b0, 8'hA5);
		ev(bus_status_pkg::EV_COLL);
		st[bus_status_pkg::B_BUSCOLL] = 1'b1;
		chk_st("coll");
		clr(bus_status_pkg::B_BUSCOLL);
		chk_st("coll clear");
		ev(bus_status_pkg::EV_RXBYTE);
		st[bus_status_pkg::B_RXFULL] = 1'b1;
		chk_st("rx full");
		far.set_levels(1'b0, 1'b0, 1'b0, 8'h3C);
		ev(bus_status_pkg::EV_RXBYTE);
		st[bus_status_pkg::B_OV] = 1'b1;
		chk_st("overflow");
		rd(bus_status_pkg::OFS_RXBUF, d);
		`CHK("rx byte", 16'h00A5, d)
		st[bus_status_pkg::B_RXFULL] = 1'b0;
		chk_st("rx read");
		clr(bus_status_pkg::B_OV);
		chk_st("ov clear");
		ev(bus_status_pkg::EV_DATA);
		st[bus_status_pkg::B_DA] = 1'b1;
		chk_st("data");
		ev(bus_status_pkg::EV_ADDR);
		st[bus_status_pkg::B_DA] = 1'b0;
		chk_st("addr");
		ev(bus_status_pkg::EV_TEN);
		ev(bus_status_pkg::EV_GCALL);
		st[bus_status_pkg::B_A10] = 1'b1;
		st[bus_status_pkg::B_GC] = 1'b1;
		chk_st("ten bit");
		ev(bus_status_pkg::EV_STOP);
		st[bus_status_pkg::B_A10] = 1'b0;
		st[bus_status_pkg::B_GC] = 1'b0;
		st[bus_status_pkg::B_P] = 1'b1;
		chk_st("stop");
		ev(bus_status_pkg::EV_START);
		st[bus_status_pkg::B_P] = 1'b0;
		st[bus_status_pkg::B_S] = 1'b1;
		chk_st("start");
		wrap_up;
	end
endmodule
